// file: src/btcc_pkg.sv
package btcc_pkg;

  // ----------------------------------------
  // field widths
  // ----------------------------------------
  localparam int TRIP_W = 2;
  localparam int SET_W = 6;
  localparam int ZONE_W = 3;
  localparam int MUXSEL_W = 4;
  localparam int TIMER_W = 24;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [SET_W-1:0] CV_RESET = 6'h00;
  localparam logic [ZONE_W-1:0] ZONE_RESET = 3'h0;

  // 200 mV margin, in charge voltage setting steps (25 mV per code)
  localparam int MARGIN_MV = 200;
  localparam int CV_STEP_MV = 25;
  localparam logic [SET_W-1:0] MARGIN_CODES = 6'(MARGIN_MV / CV_STEP_MV);

  // analog monitor channels that need sensor bias
  localparam logic [MUXSEL_W-1:0] MUX_SENSE_CH = 4'h8;
  localparam logic [MUXSEL_W-1:0] MUX_BIAS_CH = 4'h9;

  // ----------------------------------------
  // temperature zones, as reported in temp_zone_status
  // ----------------------------------------
  typedef enum logic [ZONE_W-1:0] {
    BTCC_ZONE_OFF = 3'b000,
    BTCC_ZONE_COLD = 3'b001,
    BTCC_ZONE_COOL = 3'b010,
    BTCC_ZONE_NORMAL = 3'b011,
    BTCC_ZONE_WARM = 3'b100,
    BTCC_ZONE_HOT = 3'b101
  } btcc_zone_t;

  // ----------------------------------------
  // charger states
  // ----------------------------------------
  typedef enum logic [3:0] {
    BTCC_ST_OFF = 4'b0000,
    BTCC_ST_PREQ = 4'b0001,
    BTCC_ST_CC = 4'b0010,
    BTCC_ST_CV = 4'b0011,
    BTCC_ST_TOPOFF = 4'b0100,
    BTCC_ST_DONE = 4'b0101,
    BTCC_ST_JCC = 4'b0110,
    BTCC_ST_JCV = 4'b0111,
    BTCC_ST_PQFLT = 4'b1000,
    BTCC_ST_FCFLT = 4'b1001,
    BTCC_ST_TEMPFLT = 4'b1010
  } btcc_state_t;

  // comparator outputs from the thermistor front end, active when crossed
  typedef struct packed {
    logic hot;
    logic warm;
    logic cool;
    logic cold;
  } btcc_trips_t;

  // threshold selects
  typedef struct packed {
    logic [TRIP_W-1:0] hot;
    logic [TRIP_W-1:0] warm;
    logic [TRIP_W-1:0] cool;
    logic [TRIP_W-1:0] cold;
  } btcc_thresh_t;

  // charger progress conditions from the base charger
  typedef struct packed {
    logic below_pq;
    logic at_cv;
    logic below_term;
    logic need_restart;
  } btcc_chg_cond_t;

endpackage : btcc_pkg

// file: src/btcc_zone_dec.sv
`timescale 1ns/1ps
// ----------------------------------------
// zone decode from synchronised comparator trips
// ----------------------------------------
module btcc_zone_dec (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic enable,
  input wire btcc_pkg::btcc_trips_t trips_async,
  output btcc_pkg::btcc_zone_t zone
);
  import btcc_pkg::*;

  btcc_trips_t meta_q;
  btcc_trips_t sync_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clk_en) begin
      meta_q <= trips_async;
      sync_q <= meta_q;
    end
  end

  // hot and cold checked first so extreme limits win over warm and cool
  assign zone = !enable ? BTCC_ZONE_OFF :
                sync_q.hot ? BTCC_ZONE_HOT :
                sync_q.cold ? BTCC_ZONE_COLD :
                sync_q.warm ? BTCC_ZONE_WARM :
                sync_q.cool ? BTCC_ZONE_COOL : BTCC_ZONE_NORMAL;

endmodule : btcc_zone_dec

// file: src/btcc_top.sv
`timescale 1ns/1ps
// Functional notes
// - hot or cold zone moves the charger into temperature fault
// - temperature fault: no charge current, battery kept off the system rail
// - temperature fault only reachable with monitoring enabled
// - temperature fault beats other faults; leaves on disable or normal temperature
// - leaving temperature fault returns to the remembered previous state; with monitoring off a saved twin returns as its normal state
// - charger timers hold during temperature fault and then resume
// - modified charge states only with monitoring enabled
// - warm or cool zone inside hot/cold limits enters modified states
// - modified states use alternate current and voltage settings
// - alternate settings kept separately; may equal the normal ones
// - modified states left on normal temperature or monitoring disabled
// - normal band uses normal settings, no modified state
// - margin violation lowers charge voltage setting and raises config error
// - with monitoring on, sensor voltage compared continuously to thresholds
// - zone reported in status; change raises maskable interrupt
// - four thresholds each chosen by independent two-bit selects
// - sensor bias on when charge input valid and monitoring enabled
// - sensor bias on when monitor mux selects sense or bias node
// - mux selection never disturbs temperature comparators or response
module btcc_top #(
  parameter int TIMER_W = btcc_pkg::TIMER_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic charge_input,
  input wire logic charger_enable,
  input wire logic temp_monitor_enable,
  input wire btcc_pkg::btcc_thresh_t trip_selects,
  input wire btcc_pkg::btcc_trips_t trips_async,
  input wire btcc_pkg::btcc_chg_cond_t chg_cond,
  input wire logic [btcc_pkg::SET_W-1:0] cv_write_data,
  input wire logic cv_write,
  input wire logic [btcc_pkg::SET_W-1:0] constant_current_level,
  input wire logic [btcc_pkg::SET_W-1:0] alt_charge_current_setting,
  input wire logic [btcc_pkg::SET_W-1:0] alt_charge_voltage_setting,
  input wire logic [btcc_pkg::SET_W-1:0] system_rail_target,
  input wire logic [btcc_pkg::MUXSEL_W-1:0] mux_select,
  input wire logic temp_irq_mask,
  input wire logic temp_irq_clear,
  input wire logic cfg_irq_clear,
  input wire logic [TIMER_W-1:0] pq_limit,
  input wire logic [TIMER_W-1:0] fc_limit,
  input wire logic [TIMER_W-1:0] topoff_limit,
  output btcc_pkg::btcc_state_t charger_state,
  output btcc_pkg::btcc_zone_t temp_zone_status,
  output logic temp_zone_change_irq,
  output logic sys_config_error_irq,
  output logic [btcc_pkg::SET_W-1:0] charge_voltage_setting,
  output logic [btcc_pkg::SET_W-1:0] regulation_voltage_level,
  output logic [btcc_pkg::SET_W-1:0] charge_current_out,
  output logic charge_on,
  output logic batt_connect,
  output logic sensor_bias_node,
  output logic [btcc_pkg::TRIP_W*4-1:0] comp_trip_select
);
  import btcc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] cin_meta_q;
  logic [1:0] cin_sync_q;
  btcc_zone_t zone;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cin_meta_q <= '0;
      cin_sync_q <= '0;
    end else if (clk_en) begin
      cin_meta_q <= {chg_cond.below_pq, charge_input};
      cin_sync_q <= cin_meta_q;
    end
  end

  wire cin_valid = cin_sync_q[0];

  // mux select only feeds the bias, not this decoder
  btcc_zone_dec u_zone (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable(temp_monitor_enable),
    .trips_async(trips_async),
    .zone(zone)
  );

  // ----------------------------------------
  // zone classes
  // ----------------------------------------
  wire zone_extreme = temp_monitor_enable &&
                      (zone == BTCC_ZONE_HOT || zone == BTCC_ZONE_COLD);
  wire zone_modified = temp_monitor_enable &&
                       (zone == BTCC_ZONE_WARM || zone == BTCC_ZONE_COOL);

  function automatic logic is_fast(input btcc_state_t s);
    is_fast = (s == BTCC_ST_CC || s == BTCC_ST_CV ||
               s == BTCC_ST_JCC || s == BTCC_ST_JCV);
  endfunction : is_fast

  function automatic btcc_state_t to_normal(input btcc_state_t s);
    to_normal = (s == BTCC_ST_JCC) ? BTCC_ST_CC :
                (s == BTCC_ST_JCV) ? BTCC_ST_CV : s;
  endfunction : to_normal

  // ----------------------------------------
  // charger state machine
  // ----------------------------------------
  btcc_state_t state_q;
  btcc_state_t state_d;
  btcc_state_t prev_q;
  btcc_state_t base_d;
  logic [TIMER_W-1:0] timer_q;
  logic [TIMER_W-1:0] timer_d;
  logic timer_exp;

  always_comb begin
    // twins fall back to their normal state unless still warm or cool
    base_d = to_normal(state_q);
    case (to_normal(state_q))
      BTCC_ST_OFF: begin
        if (cin_valid && charger_enable && chg_cond.need_restart) begin
          base_d = cin_sync_q[1] ? BTCC_ST_PREQ : BTCC_ST_CC;
        end
      end
      BTCC_ST_PREQ: begin
        if (timer_exp) begin
          base_d = BTCC_ST_PQFLT;
        end else if (!cin_sync_q[1]) begin
          base_d = BTCC_ST_CC;
        end
      end
      BTCC_ST_CC: begin
        if (timer_exp) begin
          base_d = BTCC_ST_FCFLT;
        end else if (chg_cond.at_cv) begin
          base_d = BTCC_ST_CV;
        end
      end
      BTCC_ST_CV: begin
        if (timer_exp) begin
          base_d = BTCC_ST_FCFLT;
        end else if (chg_cond.below_term) begin
          base_d = BTCC_ST_TOPOFF;
        end
      end
      BTCC_ST_TOPOFF: begin
        if (timer_exp) begin
          base_d = BTCC_ST_DONE;
        end
      end
      BTCC_ST_DONE: begin
        if (chg_cond.need_restart) begin
          base_d = BTCC_ST_CC;
        end
      end
      default: base_d = to_normal(state_q);
    endcase
    // fast states take their modified twin while warm or cool
    if (zone_modified && base_d == BTCC_ST_CC) begin
      base_d = BTCC_ST_JCC;
    end else if (zone_modified && base_d == BTCC_ST_CV) begin
      base_d = BTCC_ST_JCV;
    end else begin
      base_d = base_d;
    end
    if (!cin_valid || !charger_enable) begin
      state_d = BTCC_ST_OFF;
    end else if (state_q == BTCC_ST_TEMPFLT) begin
      // a saved twin is not restored once monitoring is off
      state_d = zone_extreme ? BTCC_ST_TEMPFLT :
                temp_monitor_enable ? prev_q : to_normal(prev_q);
    end else if (zone_extreme) begin
      state_d = BTCC_ST_TEMPFLT;
    end else begin
      state_d = base_d;
    end
  end

  // one timer; restarts on entering a new timed phase, held in fault
  wire phase_change = (to_normal(state_d) != to_normal(state_q)) &&
                      !(is_fast(state_d) && is_fast(state_q)) &&
                      state_d != BTCC_ST_TEMPFLT && state_q != BTCC_ST_TEMPFLT;
  wire [TIMER_W-1:0] tlimit = (to_normal(state_q) == BTCC_ST_PREQ) ? pq_limit :
                              (to_normal(state_q) == BTCC_ST_TOPOFF) ? topoff_limit :
                              fc_limit;
  assign timer_exp = (timer_q >= tlimit);

  always_comb begin
    if (state_d == BTCC_ST_OFF || phase_change) begin
      timer_d = '0;
    end else if (state_q == BTCC_ST_TEMPFLT || state_d == BTCC_ST_TEMPFLT) begin
      timer_d = timer_q;
    end else if (!timer_exp) begin
      timer_d = timer_q + TIMER_W'(1);
    end else begin
      timer_d = timer_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BTCC_ST_OFF;
      prev_q <= BTCC_ST_OFF;
      timer_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      timer_q <= timer_d;
      if (state_d == BTCC_ST_TEMPFLT && state_q != BTCC_ST_TEMPFLT) begin
        prev_q <= state_q;
      end
    end
  end

  // ----------------------------------------
  // charge voltage setting and margin check
  // ----------------------------------------
  logic [SET_W-1:0] cv_q;
  logic cv_cut_q;
  wire [SET_W:0] cv_ceiling = {1'b0, system_rail_target} - {1'b0, MARGIN_CODES};
  wire cv_ceiling_neg = cv_ceiling[SET_W];
  wire cv_over = cv_ceiling_neg || (cv_q > cv_ceiling[SET_W-1:0]);
  wire [SET_W-1:0] cv_fixed = cv_ceiling_neg ? '0 : cv_ceiling[SET_W-1:0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cv_q <= CV_RESET;
      cv_cut_q <= 1'b0;
    end else if (clk_en) begin
      if (cv_over) begin
        cv_q <= cv_fixed;
      end else if (cv_write) begin
        cv_q <= cv_write_data;
      end
      cv_cut_q <= cv_over;
    end
  end

  // ----------------------------------------
  // status and interrupts
  // ----------------------------------------
  btcc_zone_t zone_q;
  logic tirq_q;
  logic cirq_q;
  wire zone_changed = (zone != zone_q);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_q <= btcc_zone_t'(ZONE_RESET);
      tirq_q <= 1'b0;
      cirq_q <= 1'b0;
    end else if (clk_en) begin
      zone_q <= zone;
      // set beats clear
      tirq_q <= (zone_changed && !temp_irq_mask) || (tirq_q && !temp_irq_clear);
      cirq_q <= cv_cut_q || (cirq_q && !cfg_irq_clear);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire in_mod = (state_q == BTCC_ST_JCC || state_q == BTCC_ST_JCV);
  wire charging = (state_q == BTCC_ST_PREQ) || is_fast(state_q) ||
                  (state_q == BTCC_ST_TOPOFF);
  // separate alternate settings chosen only in modified states
  wire [SET_W-1:0] vreg_sel = in_mod ? alt_charge_voltage_setting : cv_q;
  wire [SET_W-1:0] icc_sel = in_mod ? alt_charge_current_setting :
                             constant_current_level;
  wire bias_on = (cin_valid && temp_monitor_enable) ||
                 (mux_select == MUX_SENSE_CH) || (mux_select == MUX_BIAS_CH);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      charger_state <= BTCC_ST_OFF;
      temp_zone_status <= btcc_zone_t'(ZONE_RESET);
      temp_zone_change_irq <= 1'b0;
      sys_config_error_irq <= 1'b0;
      charge_voltage_setting <= CV_RESET;
      regulation_voltage_level <= CV_RESET;
      charge_current_out <= '0;
      charge_on <= 1'b0;
      batt_connect <= 1'b1;
      sensor_bias_node <= 1'b0;
      comp_trip_select <= '0;
    end else if (clk_en) begin
      charger_state <= state_q;
      temp_zone_status <= zone_q;
      temp_zone_change_irq <= tirq_q;
      sys_config_error_irq <= cirq_q;
      charge_voltage_setting <= cv_q;
      regulation_voltage_level <= vreg_sel;
      charge_current_out <= charging ? icc_sel : '0;
      charge_on <= charging;
      batt_connect <= (state_q == BTCC_ST_OFF) && !cin_valid;
      sensor_bias_node <= bias_on;
      comp_trip_select <= trip_selects;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_fault_entry: assert property (clk_en && cin_valid && charger_enable && zone_extreme
    |=> state_q == BTCC_ST_TEMPFLT) else $error("hot or cold did not fault");
  a_fault_nocharge: assert property (state_q == BTCC_ST_TEMPFLT && clk_en
    |=> !charge_on && !batt_connect) else $error("charge in temp fault");
  a_fault_needs_en: assert property (!temp_monitor_enable
    |-> state_d != BTCC_ST_TEMPFLT) else $error("fault with monitor off");
  a_fault_exit: assert property (state_q == BTCC_ST_TEMPFLT && clk_en && !zone_extreme
    && cin_valid && charger_enable
    |=> state_q == ($past(temp_monitor_enable) ? $past(prev_q) : to_normal($past(prev_q))))
    else $error("fault exit lost state");
  a_timer_hold: assert property (state_q == BTCC_ST_TEMPFLT && cin_valid && charger_enable
    |=> timer_q == $past(timer_q)) else $error("timer ran in fault");
  a_mod_needs_en: assert property (!temp_monitor_enable
    |-> state_d != BTCC_ST_JCC && state_d != BTCC_ST_JCV)
    else $error("modified state with monitor off");
  a_mod_setting: assert property (clk_en && in_mod
    |=> regulation_voltage_level == $past(alt_charge_voltage_setting))
    else $error("alternate voltage not used");
  a_margin_fix: assert property (clk_en && cv_over
    |=> ($past(cv_ceiling_neg) ? cv_q == '0 : cv_q <= $past(cv_ceiling[SET_W-1:0])))
    else $error("charge voltage not lowered");
  a_zone_irq: assert property (clk_en && zone_changed && !temp_irq_mask
    |=> tirq_q) else $error("zone change irq missing");
  a_bias_on: assert property (clk_en && (mux_select == MUX_SENSE_CH)
    |=> sensor_bias_node) else $error("bias off for conversion");

  c_temp_fault: cover property (state_q == BTCC_ST_TEMPFLT ##1 state_q != BTCC_ST_TEMPFLT);
  c_modified: cover property (state_q == BTCC_ST_JCC);
  c_margin: cover property (cirq_q);
  c_zone_irq: cover property (temp_zone_change_irq);

endmodule : btcc_top

// file: tb/btcc_therm_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// thermistor front end: temperature level to comparator trips
// ----------------------------------------
// level 0 cold, 1 cool, 2 normal, 3 warm, 4 hot
module btcc_therm_model (
  input wire logic [2:0] temp_level,
  output btcc_pkg::btcc_trips_t trips
);
  import btcc_pkg::*;
  // trips nest: a hot battery has also crossed the warm trip
  assign trips.hot = (temp_level == 3'h4);
  assign trips.warm = (temp_level >= 3'h3);
  assign trips.cool = (temp_level <= 3'h1);
  assign trips.cold = (temp_level == 3'h0);
endmodule : btcc_therm_model

// file: tb/test_battery_thermal_charge_control.sv
`timescale 1ns/1ps
module test_battery_thermal_charge_control;
  import btcc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic charge_input = 1'b1;
  logic charger_enable = 1'b0;
  logic temp_monitor_enable = 1'b1;
  btcc_thresh_t trip_selects = 8'h00;
  btcc_trips_t trips;
  btcc_chg_cond_t chg_cond = 4'h1;
  logic [SET_W-1:0] cv_write_data = 6'h00;
  logic cv_write = 1'b0;
  logic [SET_W-1:0] cc_lvl = 6'h2a;
  logic [SET_W-1:0] alt_cc = 6'h11;
  logic [SET_W-1:0] alt_cv = 6'h18;
  logic [SET_W-1:0] rail = 6'h30;
  logic [MUXSEL_W-1:0] mux_select = 4'h0;
  logic temp_irq_mask = 1'b0;
  logic temp_irq_clear = 1'b0;
  logic cfg_irq_clear = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] temp_level = 3'h2;
  btcc_state_t charger_state;
  btcc_zone_t temp_zone_status;
  logic temp_zone_change_irq, sys_config_error_irq, charge_on, batt_connect, sensor_bias_node;
  logic [SET_W-1:0] charge_voltage_setting, regulation_voltage_level, charge_current_out;
  logic [TRIP_W*4-1:0] comp_trip_select;
  int bad_count = 0;
  int n_compared = 0;

  always #2.5 core_clk = ~core_clk;

  btcc_therm_model u_therm (.temp_level(temp_level), .trips(trips));

  btcc_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .charge_input(charge_input),
    .charger_enable(charger_enable), .temp_monitor_enable(temp_monitor_enable),
    .trip_selects(trip_selects), .trips_async(trips), .chg_cond(chg_cond),
    .cv_write_data(cv_write_data), .cv_write(cv_write), .constant_current_level(cc_lvl),
    .alt_charge_current_setting(alt_cc), .alt_charge_voltage_setting(alt_cv),
    .system_rail_target(rail), .mux_select(mux_select), .temp_irq_mask(temp_irq_mask),
    .temp_irq_clear(temp_irq_clear), .cfg_irq_clear(cfg_irq_clear),
    .pq_limit(24'h000100), .fc_limit(24'h00012c), .topoff_limit(24'h000100),
    .charger_state(charger_state), .temp_zone_status(temp_zone_status),
    .temp_zone_change_irq(temp_zone_change_irq), .sys_config_error_irq(sys_config_error_irq),
    .charge_voltage_setting(charge_voltage_setting),
    .regulation_voltage_level(regulation_voltage_level),
    .charge_current_out(charge_current_out), .charge_on(charge_on),
    .batt_connect(batt_connect), .sensor_bias_node(sensor_bias_node),
    .comp_trip_select(comp_trip_select)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task wait_st(input btcc_state_t s, input int lim);
    int i;
    i = 0;
    while (charger_state !== s && i < lim) begin
      cyc(1);
      i++;
    end
    chk(8'(charger_state), 8'(s), "charger state");
  endtask : wait_st

  // restarting the charger also restarts the safety timer
  task start_charge;
    charger_enable = 1'b0;
    temp_level = 3'h2;
    cyc(4);
    charger_enable = 1'b1;
    wait_st(BTCC_ST_CC, 40);
  endtask : start_charge

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_margin;
    cv_write_data = 6'h20;
    cv_write = 1'b1;
    cyc(1);
    cv_write = 1'b0;
    cyc(4);
    chk(8'(charge_voltage_setting), 8'h20, "cv kept");
    chk(8'(sys_config_error_irq), 8'h0, "no cfg irq");
    rail = 6'h25;
    cyc(6);
    chk(8'(charge_voltage_setting), 8'h1d, "cv lowered");
    chk(8'(sys_config_error_irq), 8'h1, "cfg irq");
    rail = 6'h30;
    cfg_irq_clear = 1'b1;
    cyc(1);
    cfg_irq_clear = 1'b0;
    cyc(2);
    chk(8'(sys_config_error_irq), 8'h0, "cfg irq cleared");
  endtask : t_margin

  task t_modified;
    logic [2:0] lv;
    start_charge();
    chk(8'(charge_current_out), 8'(cc_lvl), "normal current");
    chk(8'(regulation_voltage_level), 8'h1d, "normal voltage");
    chk(8'(sensor_bias_node), 8'h1, "bias on");
    for (int k = 0; k < 2; k++) begin
      lv = (k == 0) ? 3'h3 : 3'h1;
      temp_level = lv;
      wait_st(BTCC_ST_JCC, 12);
      chk(8'(charge_current_out), 8'(alt_cc), "alt current");
      chk(8'(regulation_voltage_level), 8'(alt_cv), "alt voltage");
      chk(8'(temp_zone_status), (k == 0) ? 8'h4 : 8'h2, "zone");
      chk(8'(temp_zone_change_irq), 8'h1, "zone irq");
      temp_irq_clear = 1'b1;
      cyc(1);
      temp_irq_clear = 1'b0;
      temp_level = 3'h2;
      wait_st(BTCC_ST_CC, 12);
      chk(8'(charge_current_out), 8'(cc_lvl), "normal again");
      temp_irq_clear = 1'b1;
      cyc(1);
      temp_irq_clear = 1'b0;
    end
    temp_irq_mask = 1'b1;
    temp_level = 3'h3;
    wait_st(BTCC_ST_JCC, 12);
    chk(8'(temp_zone_change_irq), 8'h0, "masked irq");
    temp_level = 3'h2;
    wait_st(BTCC_ST_CC, 12);
    temp_irq_mask = 1'b0;
  endtask : t_modified

  task t_fault;
    start_charge();
    cyc(40);
    temp_level = 3'h4;
    wait_st(BTCC_ST_TEMPFLT, 12);
    chk(8'(charge_on), 8'h0, "no current");
    chk(8'(batt_connect), 8'h0, "batt off");
    chk(8'(temp_zone_status), 8'h5, "zone hot");
    cyc(400);
    temp_level = 3'h2;
    wait_st(BTCC_ST_CC, 12);
    // timer resumed: expiry comes well before a full fresh period
    wait_st(BTCC_ST_FCFLT, 285);
    start_charge();
    temp_level = 3'h0;
    wait_st(BTCC_ST_TEMPFLT, 12);
    temp_monitor_enable = 1'b0;
    wait_st(BTCC_ST_CC, 12);
    cyc(12);
    chk(8'(charger_state), 8'(BTCC_ST_CC), "no fault when off");
    temp_level = 3'h3;
    cyc(12);
    chk(8'(charger_state), 8'(BTCC_ST_CC), "no modified when off");
    chk(8'(sensor_bias_node), 8'h0, "bias off");
    for (int k = 0; k < 3; k++) begin
      mux_select = (k == 0) ? MUX_SENSE_CH : (k == 1) ? MUX_BIAS_CH : 4'h5;
      cyc(4);
      chk(8'(sensor_bias_node), (k < 2) ? 8'h1 : 8'h0, "mux bias");
    end
    mux_select = 4'h0;
    temp_monitor_enable = 1'b1;
    temp_level = 3'h2;
  endtask : t_fault

  task t_mux;
    start_charge();
    mux_select = MUX_SENSE_CH;
    temp_level = 3'h3;
    wait_st(BTCC_ST_JCC, 12);
    chk(8'(temp_zone_status), 8'h4, "zone with mux");
    mux_select = 4'h0;
    for (int k = 0; k < 2; k++) begin
      trip_selects = (k == 0) ? 8'h1b : 8'he4;
      cyc(3);
      chk(comp_trip_select, trip_selects, "trip selects");
    end
    // frozen clock enable must hide the hot battery until released
    clk_en = 1'b0;
    temp_level = 3'h4;
    cyc(10);
    chk(8'(charger_state), 8'(BTCC_ST_JCC), "frozen state");
    clk_en = 1'b1;
    wait_st(BTCC_ST_TEMPFLT, 12);
    temp_level = 3'h2;
    wait_st(BTCC_ST_JCC, 12);
    wait_st(BTCC_ST_CC, 12);
  endtask : t_mux

  task print_verdict;
    $display("checks %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (19) @(posedge core_clk);
    #1;
    chk(8'(charger_state), 8'(BTCC_ST_OFF), "reset state");
    chk(8'(temp_zone_status), 8'h0, "reset zone");
    chk(8'({charge_on, batt_connect, sensor_bias_node}), 8'h2, "reset outputs");
    @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    cyc(4);
    t_margin();
    t_modified();
    t_fault();
    t_mux();
    print_verdict();
  end

  // ----------------------------------------
  // watchdog: the tests need well under 5000 cycles
  // ----------------------------------------
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule : test_battery_thermal_charge_control
